// File: pkg/tca_defines.vh
// Register map, field positions, reset values and timing figures of the conversion and alarm block.
`ifndef TCA_DEFINES_VH
`define TCA_DEFINES_VH

// Register addresses carried in bits [5:3] of the command byte.
`define TCA_ADDR_STATUS 3'h0
`define TCA_ADDR_SETUP 3'h1
`define TCA_ADDR_TEMP 3'h2
`define TCA_ADDR_ID 3'h3
`define TCA_ADDR_CRIT 3'h4
`define TCA_ADDR_HYST 3'h5
`define TCA_ADDR_HIGH 3'h6
`define TCA_ADDR_LOW 3'h7

// Command byte fields and the two continuous read commands.
`define TCA_CMD_READ 6
`define TCA_CMD_ADDR_HI 5
`define TCA_CMD_ADDR_LO 3
`define TCA_CMD_CONT 2
`define TCA_CMD_CONT_ENTER 8'h54
`define TCA_CMD_CONT_EXIT 8'h50

// Setup register fields.
`define TCA_CFG_QUEUE_HI 1
`define TCA_CFG_QUEUE_LO 0
`define TCA_CFG_CT_POL 2
`define TCA_CFG_INT_POL 3
`define TCA_CFG_INT_MODE 4
`define TCA_CFG_MODE_HI 6
`define TCA_CFG_MODE_LO 5
`define TCA_CFG_RES16 7

// Operation modes in setup bits [6:5].
`define TCA_MODE_NORMAL 2'h0
`define TCA_MODE_ONESHOT 2'h1
`define TCA_MODE_SPS 2'h2
`define TCA_MODE_SHUTDOWN 2'h3

// Power-on values.
`define TCA_RST_STATUS 8'h80
`define TCA_RST_SETUP 8'h00
`define TCA_RST_TEMP 16'h0000
`define TCA_RST_CRIT 16'h4980
`define TCA_RST_HYST 8'h05
`define TCA_RST_HIGH 16'h2000
`define TCA_RST_LOW 16'h0500

// Fault queue depth limit and serial reset run length.
`define TCA_QUEUE_MAX 3'h4
`define TCA_ONES_LAST 5'h1f

// Timing figures in milliseconds and the clock rate in kHz.
`define TCA_CLK_KHZ 50000
`define TCA_FAST_MS 6
`define TCA_CONV_MS 240
`define TCA_SPS_CONV_MS 60
`define TCA_SPS_IDLE_MS 940
`define TCA_WAKE_MS 1

`endif

// File: src/tca_alarm.v
// One open-drain alarm output with comparator and latched interrupt behaviour.
module tca_alarm (
  input wire clk, // System clock.
  input wire rst, // Synchronous reset, active high.
  input wire eval, // One-cycle pulse at each finished conversion.
  input wire setCond, // Fault queue tripped on this limit.
  input wire insideCond, // Result back inside the limit with hysteresis.
  input wire intMode, // High selects interrupt behaviour.
  input wire activeHigh, // High makes the active level a released pin.
  input wire oneShot, // Device is in one-shot operation.
  input wire readClr, // Pulse for any register read.
  input wire modeWr, // Pulse for a write to the setup register.
  output wire pinOut, // Open-drain data, always low.
  output wire pinOe // High while the pin is pulled low.
);

  reg active_ff;
  reg inside_ff;
  reg oe_ff;
  reg nxt_active;

  // Alarm state; a set on the same cycle as a clear always wins.
  always @* begin
    nxt_active = active_ff;
    if (intMode) begin
      if (readClr) begin
        nxt_active = 1'b0;
      end
    end else if (eval && insideCond && !oneShot) begin
      nxt_active = 1'b0;
    end else if (modeWr && oneShot && inside_ff) begin
      nxt_active = 1'b0;
    end
    if (eval && setCond) begin
      nxt_active = 1'b1;
    end
  end

  // The pin level is registered so the output never glitches on a mode change.
  always @(posedge clk) begin
    if (rst) begin
      active_ff <= 1'b0;
      inside_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      active_ff <= nxt_active;
      if (eval) begin
        inside_ff <= insideCond;
      end
      oe_ff <= nxt_active ^ activeHigh;
    end
  end

  assign pinOut = 1'b0;
  assign pinOe = oe_ff;

endmodule

// File: src/tca_sync.v
// Two flip-flop synchroniser for pin inputs.
module tca_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  input wire clk, // System clock.
  input wire rst, // Synchronous reset, active high.
  input wire [WIDTH-1:0] pinIn, // Asynchronous pin levels.
  output wire [WIDTH-1:0] syncOut // Levels safe to read in the clk domain.
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // The first stage feeds only the second, so a metastable level never reaches logic.
  always @(posedge clk) begin
    if (rst) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= pinIn;
      sync_ff <= meta_ff;
    end
  end

  assign syncOut = sync_ff;

endmodule

// File: src/tca_top.v
// Conversion sequencer, serial register port and limit alarms of the temperature sensor.
`include "tca_defines.vh"

module tca_top #(
  parameter [7:0] ID_VALUE = 8'h5a, // Identity byte, value arbitrary.
  parameter FAST_CYC = `TCA_FAST_MS * `TCA_CLK_KHZ,
  parameter CONV_CYC = `TCA_CONV_MS * `TCA_CLK_KHZ,
  parameter SPS_CONV_CYC = `TCA_SPS_CONV_MS * `TCA_CLK_KHZ,
  parameter SPS_IDLE_CYC = `TCA_SPS_IDLE_MS * `TCA_CLK_KHZ,
  parameter WAKE_CYC = `TCA_WAKE_MS * `TCA_CLK_KHZ
) (
  input wire clk, // System clock, 50 MHz.
  input wire rst, // Synchronous reset, active high.
  input wire sclk, // Serial clock pin, idles high.
  input wire csN, // Chip select pin, active low.
  input wire din, // Serial data input pin.
  output wire dout, // Serial data output.
  output wire doutOe, // High while dout is driven.
  input wire [15:0] tempCode, // Modulator result, 1/128 C per LSB, same clock.
  output wire criticalAlarmOut, // Critical alarm open-drain data.
  output wire criticalAlarmOe, // High while critical alarm pin is pulled low.
  output wire limitAlarmOut, // Limit alarm open-drain data.
  output wire limitAlarmOe, // High while limit alarm pin is pulled low.
  output wire convBusy // High while a conversion runs.
);

  localparam SEQ_FAST = 3'h0;
  localparam SEQ_CONV = 3'h1;
  localparam SEQ_IDLE = 3'h2;
  localparam SEQ_SHUT = 3'h3;
  localparam SEQ_WAKE = 3'h4;

  localparam PH_CMD = 2'h0;
  localparam PH_DATA = 2'h1;
  localparam PH_DONE = 2'h2;
  localparam PH_CONT = 2'h3;

  wire sclkS;
  wire csnS;
  wire dinS;
  reg sclkPrev_ff;
  wire sclkRise;
  wire sclkFall;

  reg [7:0] setup_ff;
  reg [15:0] temp_ff;
  reg [15:0] crit_ff;
  reg [7:0] hyst_ff;
  reg [15:0] high_ff;
  reg [15:0] low_ff;
  reg rdyN_ff;
  reg critFlag_ff;
  reg highFlag_ff;
  reg lowFlag_ff;

  reg [2:0] seq_ff;
  reg [31:0] cnt_ff;
  reg convShort_ff;
  reg [2:0] faultCnt_ff;

  reg [1:0] phase_ff;
  reg [4:0] bitCnt_ff;
  reg [15:0] shIn_ff;
  reg [15:0] shOut_ff;
  reg [7:0] cmd_ff;
  reg cont_ff;
  reg [4:0] ones_ff;
  reg dout_ff;

  tca_sync #(
    .WIDTH(3),
    .INIT(3'h7)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pinIn({sclk, csN, din}),
    .syncOut({sclkS, csnS, dinS})
  );

  assign sclkRise = sclkS & ~sclkPrev_ff;
  assign sclkFall = ~sclkS & sclkPrev_ff;

  // Serial frame decoding: byte completion, register selection and access strobes.
  wire [7:0] byteIn = {shIn_ff[6:0], dinS};
  wire [15:0] wordIn = {shIn_ff[14:0], dinS};
  wire active = ~csnS;
  wire cmdDone = active && sclkRise && (phase_ff == PH_CMD) && (bitCnt_ff == 5'h7);
  wire [2:0] curAddr = cmdDone ? byteIn[`TCA_CMD_ADDR_HI:`TCA_CMD_ADDR_LO] :
    cmd_ff[`TCA_CMD_ADDR_HI:`TCA_CMD_ADDR_LO];
  wire wide = (curAddr == `TCA_ADDR_TEMP) || (curAddr == `TCA_ADDR_CRIT) ||
    (curAddr == `TCA_ADDR_HIGH) || (curAddr == `TCA_ADDR_LOW);
  wire [4:0] lastBit = wide ? 5'hf : 5'h7;
  wire contExit = active && sclkRise && (phase_ff == PH_CONT) && (bitCnt_ff[2:0] == 3'h7) &&
    (byteIn == `TCA_CMD_CONT_EXIT);
  wire contBurst = active && sclkRise && (phase_ff == PH_CONT) && (bitCnt_ff == 5'hf) && !contExit;
  wire cmdRead = cmdDone && byteIn[`TCA_CMD_READ];
  wire cmdEnter = cmdRead && byteIn[`TCA_CMD_CONT] &&
    (byteIn[`TCA_CMD_ADDR_HI:`TCA_CMD_ADDR_LO] == `TCA_ADDR_TEMP);
  wire regRead = cmdRead || contExit || contBurst;
  wire [2:0] rdAddr = (contExit || contBurst) ? `TCA_ADDR_TEMP : curAddr;
  wire dataEnd = active && sclkRise && (phase_ff == PH_DATA) && (bitCnt_ff == lastBit);
  wire regWrite = dataEnd && !cmd_ff[`TCA_CMD_READ];
  wire setupWr = regWrite && (curAddr == `TCA_ADDR_SETUP);
  wire [1:0] wrMode = wordIn[`TCA_CFG_MODE_HI:`TCA_CFG_MODE_LO];
  wire [1:0] mode = setup_ff[`TCA_CFG_MODE_HI:`TCA_CFG_MODE_LO];
  wire serialReset = active && sclkRise && dinS && (ones_ff == `TCA_ONES_LAST);
  wire convRun = (seq_ff == SEQ_CONV) || (seq_ff == SEQ_FAST);

  // Temperature as read out: in 13-bit format the three low bits carry the flags.
  wire res16 = setup_ff[`TCA_CFG_RES16];
  wire [15:0] tempOut = res16 ? temp_ff : {temp_ff[15:3], critFlag_ff, highFlag_ff, lowFlag_ff};
  wire blockTemp = (cont_ff || contBurst) && !contExit && convRun;

  reg [15:0] rdVal;
  always @* begin
    case (rdAddr)
      `TCA_ADDR_STATUS: rdVal = {rdyN_ff, critFlag_ff, highFlag_ff, lowFlag_ff, 4'h0, 8'h00};
      `TCA_ADDR_SETUP: rdVal = {setup_ff, 8'h00};
      `TCA_ADDR_TEMP: rdVal = blockTemp ? 16'h0000 : tempOut;
      `TCA_ADDR_ID: rdVal = {ID_VALUE, 8'h00};
      `TCA_ADDR_CRIT: rdVal = crit_ff;
      `TCA_ADDR_HYST: rdVal = {hyst_ff, 8'h00};
      `TCA_ADDR_HIGH: rdVal = high_ff;
      default: rdVal = low_ff;
    endcase
  end

  // Serial port state; the frame restarts whenever chip select goes high.
  always @(posedge clk) begin
    if (rst) begin
      sclkPrev_ff <= 1'b1;
      phase_ff <= PH_CMD;
      bitCnt_ff <= 5'h00;
      shIn_ff <= 16'h0000;
      shOut_ff <= 16'h0000;
      cmd_ff <= 8'h00;
      cont_ff <= 1'b0;
      ones_ff <= 5'h00;
      dout_ff <= 1'b1;
    end else begin
      sclkPrev_ff <= sclkS;
      if (!active) begin
        bitCnt_ff <= 5'h00;
        phase_ff <= cont_ff ? PH_CONT : PH_CMD;
        if (cont_ff) begin
          shOut_ff <= rdVal;
        end
      end else if (serialReset) begin
        cont_ff <= 1'b0;
        phase_ff <= PH_CMD;
        bitCnt_ff <= 5'h00;
        ones_ff <= 5'h00;
      end else if (sclkRise) begin
        ones_ff <= dinS ? ones_ff + 5'h01 : 5'h00;
        shIn_ff <= wordIn;
        bitCnt_ff <= bitCnt_ff + 5'h01;
        if (cmdDone) begin
          cmd_ff <= byteIn;
          bitCnt_ff <= 5'h00;
          if (cmdRead) begin
            shOut_ff <= rdVal;
          end
          if (cmdEnter) begin
            cont_ff <= 1'b1;
            phase_ff <= PH_CONT;
          end else begin
            phase_ff <= PH_DATA;
          end
        end else if (contExit) begin
          cont_ff <= 1'b0;
          cmd_ff <= byteIn;
          phase_ff <= PH_DATA;
          bitCnt_ff <= 5'h00;
          shOut_ff <= rdVal;
        end else if (contBurst) begin
          bitCnt_ff <= 5'h00;
          shOut_ff <= rdVal;
        end else if (dataEnd) begin
          phase_ff <= PH_DONE;
        end
      end else if (sclkFall && ((phase_ff == PH_CONT) ||
          ((phase_ff == PH_DATA) && cmd_ff[`TCA_CMD_READ]))) begin
        dout_ff <= shOut_ff[15];
        shOut_ff <= {shOut_ff[14:0], 1'b0};
      end
    end
  end

  assign dout = dout_ff;
  assign doutOe = active;

  // Register writes from the serial port.
  always @(posedge clk) begin
    if (rst) begin
      setup_ff <= `TCA_RST_SETUP;
      crit_ff <= `TCA_RST_CRIT;
      hyst_ff <= `TCA_RST_HYST;
      high_ff <= `TCA_RST_HIGH;
      low_ff <= `TCA_RST_LOW;
    end else if (regWrite) begin
      case (curAddr)
        `TCA_ADDR_SETUP: setup_ff <= wordIn[7:0];
        `TCA_ADDR_CRIT: crit_ff <= wordIn;
        `TCA_ADDR_HYST: hyst_ff <= wordIn[7:0];
        `TCA_ADDR_HIGH: high_ff <= wordIn;
        `TCA_ADDR_LOW: low_ff <= wordIn;
        default: crit_ff <= crit_ff;
      endcase
    end
  end

  // Conversion sequencer. Counts are long, so each one is a parameter a bench can shorten.
  reg [2:0] nxt_seq;
  reg nxt_short;
  reg convDone;
  reg [2:0] afterSeq;
  reg afterShort;
  always @* begin
    case (mode)
      `TCA_MODE_NORMAL: afterSeq = SEQ_CONV;
      `TCA_MODE_SPS: afterSeq = SEQ_IDLE;
      default: afterSeq = SEQ_SHUT;
    endcase
    afterShort = 1'b0;
    nxt_seq = seq_ff;
    nxt_short = convShort_ff;
    convDone = 1'b0;
    case (seq_ff)
      SEQ_FAST: begin
        if (cnt_ff == FAST_CYC - 1) begin
          convDone = 1'b1;
          nxt_seq = afterSeq;
          nxt_short = afterShort;
        end
      end
      SEQ_CONV: begin
        if (cnt_ff == (convShort_ff ? SPS_CONV_CYC - 1 : CONV_CYC - 1)) begin
          convDone = 1'b1;
          nxt_seq = afterSeq;
          nxt_short = afterShort;
        end
      end
      SEQ_IDLE: begin
        if (cnt_ff == SPS_IDLE_CYC - 1) begin
          nxt_seq = (mode == `TCA_MODE_SHUTDOWN) ? SEQ_SHUT : SEQ_CONV;
          nxt_short = (mode == `TCA_MODE_SPS);
        end
      end
      SEQ_WAKE: begin
        if (cnt_ff == WAKE_CYC - 1) begin
          nxt_seq = SEQ_CONV;
          nxt_short = (mode == `TCA_MODE_SPS);
        end
      end
      SEQ_SHUT: nxt_seq = SEQ_SHUT;
      default: nxt_seq = SEQ_SHUT;
    endcase
    if (setupWr) begin
      if (wrMode == `TCA_MODE_SHUTDOWN) begin
        nxt_seq = SEQ_SHUT;
        convDone = 1'b0;
      end else if (wrMode == `TCA_MODE_ONESHOT) begin
        nxt_seq = SEQ_CONV;
        nxt_short = 1'b0;
        convDone = 1'b0;
      end else if (seq_ff == SEQ_SHUT) begin
        nxt_seq = SEQ_WAKE;
      end else if (seq_ff == SEQ_IDLE) begin
        nxt_seq = SEQ_CONV;
        nxt_short = (wrMode == `TCA_MODE_SPS);
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      seq_ff <= SEQ_FAST;
      cnt_ff <= 32'h00000000;
      convShort_ff <= 1'b0;
    end else begin
      seq_ff <= nxt_seq;
      convShort_ff <= nxt_short;
      cnt_ff <= (nxt_seq != seq_ff || convDone || (setupWr && wrMode == `TCA_MODE_ONESHOT)) ? 32'h00000000 :
        cnt_ff + 32'h00000001;
    end
  end

  assign convBusy = convRun;

  // Limit comparison on sign-extended values; 13-bit mode drops the three low bits.
  wire [15:0] tMask = res16 ? tempCode : {tempCode[15:3], 3'h0};
  wire signed [16:0] tS = {tMask[15], tMask};
  wire signed [16:0] critS = {crit_ff[15], crit_ff};
  wire signed [16:0] highS = {high_ff[15], high_ff};
  wire signed [16:0] lowS = {low_ff[15], low_ff};
  wire signed [16:0] hystS = {6'h00, hyst_ff[3:0], 7'h00};
  wire overCrit = tS > critS;
  wire overHigh = tS > highS;
  wire underLow = tS < lowS;
  wire critInside = tS < (critS - hystS);
  wire highInside = tS < (highS - hystS);
  wire lowInside = tS > (lowS + hystS);
  wire anyFault = overCrit || overHigh || underLow;

  // Fault queue: an unbroken run of faulting conversions is needed to trip the alarms.
  wire [2:0] need = {1'b0, setup_ff[`TCA_CFG_QUEUE_HI:`TCA_CFG_QUEUE_LO]} + 3'h1;
  wire [2:0] runCnt = (faultCnt_ff == `TCA_QUEUE_MAX) ? `TCA_QUEUE_MAX : faultCnt_ff + 3'h1;
  wire trip = anyFault && (runCnt >= need);

  // Results, flags and ready bit; a hardware set beats a same-cycle clear.
  wire tempRead = regRead && (rdAddr == `TCA_ADDR_TEMP);
  wire statusRead = regRead && (rdAddr == `TCA_ADDR_STATUS);
  always @(posedge clk) begin
    if (rst) begin
      temp_ff <= `TCA_RST_TEMP;
      faultCnt_ff <= 3'h0;
      rdyN_ff <= |(`TCA_RST_STATUS & 8'h80);
      critFlag_ff <= 1'b0;
      highFlag_ff <= 1'b0;
      lowFlag_ff <= 1'b0;
    end else begin
      if (convDone) begin
        temp_ff <= tempCode;
        faultCnt_ff <= anyFault ? runCnt : 3'h0;
      end
      if (convDone) begin
        rdyN_ff <= 1'b0;
      end else if (tempRead || (setupWr && (mode == `TCA_MODE_ONESHOT || mode == `TCA_MODE_SPS))) begin
        rdyN_ff <= 1'b1;
      end
      if (convDone && overCrit) begin
        critFlag_ff <= 1'b1;
      end else if (statusRead || (convDone && critInside)) begin
        critFlag_ff <= 1'b0;
      end
      if (convDone && overHigh) begin
        highFlag_ff <= 1'b1;
      end else if (statusRead || (convDone && highInside)) begin
        highFlag_ff <= 1'b0;
      end
      if (convDone && underLow) begin
        lowFlag_ff <= 1'b1;
      end else if (statusRead || (convDone && lowInside)) begin
        lowFlag_ff <= 1'b0;
      end
    end
  end

  // Both alarms share the fault queue but keep their own release conditions.
  wire intMode = setup_ff[`TCA_CFG_INT_MODE];
  wire oneShot = (mode == `TCA_MODE_ONESHOT);

  tca_alarm u_crit (
    .clk(clk),
    .rst(rst),
    .eval(convDone),
    .setCond(trip && overCrit),
    .insideCond(critInside),
    .intMode(intMode),
    .activeHigh(setup_ff[`TCA_CFG_CT_POL]),
    .oneShot(oneShot),
    .readClr(regRead),
    .modeWr(setupWr),
    .pinOut(criticalAlarmOut),
    .pinOe(criticalAlarmOe)
  );

  tca_alarm u_limit (
    .clk(clk),
    .rst(rst),
    .eval(convDone),
    .setCond(trip && (overHigh || underLow)),
    .insideCond(highInside && lowInside),
    .intMode(intMode),
    .activeHigh(setup_ff[`TCA_CFG_INT_POL]),
    .oneShot(oneShot),
    .readClr(regRead),
    .modeWr(setupWr),
    .pinOut(limitAlarmOut),
    .pinOe(limitAlarmOe)
  );

endmodule

// File: tb/tca_spi_model.sv
// Serial port controller model that frames commands and register data for the sensor.
module tca_spi_model (
  input wire logic clk, // System clock that paces the serial clock.
  input wire logic dout, // Serial data from the sensor.
  output logic sclk, // Serial clock, idles high.
  output logic csN, // Chip select, active low.
  output logic din // Serial data to the sensor.
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 5; // Half period in clk cycles, above the sampling minimum of four.

  // Idle levels; din stays low so a stray run of ones never resets the port.
  initial begin
    sclk = 1'b1;
    csN = 1'b1;
    din = 1'b0;
  end

  // Shifts n bits from bits[31] down, MSB first; the last 16 dout samples return in rd.
  task automatic frame(input logic [31:0] bits, input int n, output logic [15:0] rd);
    logic [31:0] sh;
    sh = bits;
    rd = 16'h0000;
    @(negedge clk);
    csN = 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (HALF) @(negedge clk);
      sclk = 1'b0;
      din = sh[31];
      sh = sh << 1;
      repeat (HALF) @(negedge clk);
      sclk = 1'b1;
      rd = {rd[14:0], dout};
    end
    repeat (HALF) @(negedge clk);
    csN = 1'b1;
    din = 1'b0;
    repeat (HALF) @(negedge clk);
  endtask
endmodule

// File: tb/tca_top_chk.sv
// Port-level assertions for the temperature conversion and alarm block.
module tca_top_chk #(
  parameter FAST_CYC = 20, // Fast conversion length in clk cycles.
  parameter SPS_IDLE_CYC = 60 // Idle part of the once-per-second period.
) (
  input wire clk, // System clock.
  input wire rst, // Synchronous reset, active high.
  input wire csN, // Chip select, active low.
  input wire doutOe, // Serial data output enable.
  input wire criticalAlarmOut, // Critical alarm data.
  input wire criticalAlarmOe, // Critical alarm enable.
  input wire limitAlarmOut, // Limit alarm data.
  input wire limitAlarmOe, // Limit alarm enable.
  input wire convBusy // Conversion in progress.
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned sinceRst_ff;
  int unsigned busyRun_ff;
  int unsigned idleRun_ff;
  int unsigned csnAge_ff;

  // Run lengths and frame age; changes close to a frame may come from register writes.
  always @(posedge clk) begin
    if (rst) begin
      sinceRst_ff <= 0;
      busyRun_ff <= 0;
      idleRun_ff <= 0;
      csnAge_ff <= 0;
    end else begin
      sinceRst_ff <= (sinceRst_ff < 1000) ? sinceRst_ff + 1 : sinceRst_ff;
      busyRun_ff <= convBusy ? busyRun_ff + 1 : 0;
      idleRun_ff <= convBusy ? 0 : idleRun_ff + 1;
      csnAge_ff <= !csN ? 0 : ((csnAge_ff < 1000) ? csnAge_ff + 1 : csnAge_ff);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Ends of busy and idle phases far from any frame, so no write can have cut them.
  sequence s_convEnd;
    $fell(convBusy) && csnAge_ff > 20;
  endsequence
  sequence s_idleEnd;
    $rose(convBusy) && csnAge_ff > 20 && idleRun_ff > 2;
  endsequence

  a_od_crit_low: assert property (criticalAlarmOut == 1'b0)
    else $error("critical alarm data not low");
  a_od_limit_low: assert property (limitAlarmOut == 1'b0)
    else $error("limit alarm data not low");
  a_fast_conv_busy: assert property ((sinceRst_ff >= 2 && sinceRst_ff <= FAST_CYC - 2) |-> convBusy)
    else $error("fast conversion not running after reset");
  a_conv_full_len: assert property (s_convEnd |-> busyRun_ff >= FAST_CYC - 1)
    else $error("conversion ended early");
  a_sps_idle_len: assert property (s_idleEnd |-> idleRun_ff >= SPS_IDLE_CYC - 2 && idleRun_ff <= SPS_IDLE_CYC + 2)
    else $error("idle period of wrong length");
  a_crit_at_event: assert property ($changed(criticalAlarmOe) |-> $past(convBusy) || $past(convBusy, 2) || csnAge_ff <= 4)
    else $error("critical alarm moved while idle");
  a_limit_at_event: assert property ($changed(limitAlarmOe) |-> $past(convBusy) || $past(convBusy, 2) || csnAge_ff <= 4)
    else $error("limit alarm moved while idle");
  a_alarm_reset: assert property (disable iff (1'b0) rst |=> !criticalAlarmOe && !limitAlarmOe)
    else $error("alarm driven after reset");
  a_dout_drive: assert property ((!csN) [*4] |-> doutOe)
    else $error("data output not driven in a frame");
  a_dout_release: assert property (csN [*4] |-> !doutOe)
    else $error("data output driven while deselected");
endmodule

bind tca_top tca_top_chk #(.FAST_CYC(FAST_CYC), .SPS_IDLE_CYC(SPS_IDLE_CYC)) chk_u (.clk(clk), .rst(rst), .csN(csN),
  .doutOe(doutOe),
  .criticalAlarmOut(criticalAlarmOut), .criticalAlarmOe(criticalAlarmOe), .limitAlarmOut(limitAlarmOut),
  .limitAlarmOe(limitAlarmOe), .convBusy(convBusy));

// File: tb/test_tca_top.sv
// Self-checking bench for the temperature conversion and alarm block.
`include "tca_defines.vh"
module test_tca_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0] cmd;
    int nb;
    logic [15:0] exp;
  } tca_row_t;
  localparam logic [15:0] HOT = 16'h4a00; // 148 C, above both default limits.
  localparam logic [15:0] COOL = 16'h0c80; // 25 C, inside every limit.
  localparam logic [15:0] ID_BYTE = 16'h005a; // Identity byte of the default build, value arbitrary.
  logic clk, rst, sclk, csN, din, dout, doutOe, critOut, critOe, limOut, limOe, convBusy;
  logic [15:0] tempCode, rd;
  int errCount = 0;
  int comparisons = 0;
  int cycles = 0;
  int hi;
  // Power-on reads: command, data bits and expected value.
  tca_row_t rows [8] = '{'{8'h48, 8, 16'h0000}, '{8'h50, 16, COOL}, '{8'h58, 8, ID_BYTE},
    '{8'h60, 16, `TCA_RST_CRIT}, '{8'h68, 8, 16'h0005}, '{8'h70, 16, `TCA_RST_HIGH}, '{8'h78, 16, `TCA_RST_LOW},
    '{8'h40, 8, 16'h0000}};
  // One-shot runs: temperature of each conversion beside the alarm state it leaves.
  logic [15:0] shotT [8] = '{HOT, HOT, HOT, COOL, HOT, HOT, HOT, HOT};
  logic shotA [8] = '{0, 0, 0, 0, 0, 0, 0, 1};

  // Counts are shortened to keep the run brief; the identity byte keeps its default.
  tca_top #(.FAST_CYC(20), .CONV_CYC(50), .SPS_CONV_CYC(30), .SPS_IDLE_CYC(60),
    .WAKE_CYC(10)) dut_u (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .din(din), .dout(dout),
    .doutOe(doutOe), .tempCode(tempCode), .criticalAlarmOut(critOut), .criticalAlarmOe(critOe),
    .limitAlarmOut(limOut), .limitAlarmOe(limOe), .convBusy(convBusy));
  tca_spi_model spi_u (.clk(clk), .dout(dout), .sclk(sclk), .csN(csN), .din(din));

  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // A hang ends the run as a failure.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errCount++;
      results();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    spi_u.frame({2'b00, a, 3'b000, d, 16'h0000}, 16, rd);
  endtask
  task automatic rdr(input logic [7:0] cmd, input int nb);
    spi_u.frame({cmd, 24'h000000}, nb + 8, rd);
    if (nb == 8) rd = {8'h00, rd[7:0]};
  endtask
  task automatic busyCnt(input int n);
    hi = 0;
    repeat (n) begin
      @(negedge clk);
      hi += (convBusy === 1'b1);
    end
  endtask
  task automatic alarms(input logic c, input logic l);
    check({15'h0, critOe}, {15'h0, c}, "critical alarm");
    check({15'h0, limOe}, {15'h0, l}, "limit alarm");
  endtask
  task automatic shot;
    wr(3'h1, 8'h23);
    step(60);
  endtask
  task automatic results;
    $display("Counts: %0d comparisons, %0d errors", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    tempCode = 16'h0c87;
    step(20);
    rst = 1'b0;
    step(5);
    alarms(1'b0, 1'b0);
    check({15'h0, convBusy}, 16'h0001, "fast conversion");
    foreach (rows[i]) begin
      rdr(rows[i].cmd, rows[i].nb);
      check(rd, rows[i].exp, "power-on read");
    end
    // Read-only identity byte ignores writes; wide format keeps the low bits.
    wr(3'h3, 8'hff);
    rdr(8'h58, 8);
    check(rd, ID_BYTE, "identity after write");
    wr(3'h1, 8'h80);
    step(120);
    rdr(8'h50, 16);
    check(rd, 16'h0c87, "wide result");
    wr(3'h1, 8'h00);
    tempCode = 16'h0d00;
    step(120);
    rdr(8'h50, 16);
    check(rd, 16'h0d00, "newest result");
    busyCnt(100);
    check({15'h0, hi >= 98}, 16'h0001, "back to back busy");
    // Default limits, flags in the low bits, comparator release.
    tempCode = 16'h2080;
    step(120);
    alarms(1'b0, 1'b1);
    tempCode = HOT;
    step(120);
    alarms(1'b1, 1'b1);
    rdr(8'h50, 16);
    check(rd, 16'h4a06, "flagged result");
    rdr(8'h40, 8);
    check(rd, 16'h0060, "status flags");
    tempCode = COOL;
    step(120);
    alarms(1'b0, 1'b0);
    wr(3'h1, 8'h0c);
    alarms(1'b1, 1'b1);
    // Interrupt mode latches until any read.
    wr(3'h1, 8'h10);
    tempCode = HOT;
    step(120);
    alarms(1'b1, 1'b1);
    tempCode = COOL;
    step(120);
    alarms(1'b1, 1'b1);
    rdr(8'h48, 8);
    check(rd, 16'h0010, "setup readback");
    alarms(1'b0, 1'b0);
    // One-shot fault queue of four, broken run first.
    for (int i = 0; i < 8; i++) begin
      wr(3'h1, 8'h23);
      tempCode = shotT[i];
      step(60);
      alarms(shotA[i], shotA[i]);
    end
    // Shut down after the last shot, so only the status read can clear the flags.
    rdr(8'h40, 8);
    check(rd, 16'h0060, "status before clear");
    rdr(8'h40, 8);
    check(rd, 16'h0000, "status after read");
    tempCode = COOL;
    shot();
    alarms(1'b1, 1'b1);
    shot();
    alarms(1'b0, 1'b0);
    busyCnt(100);
    check(hi[15:0], 16'h0000, "idle after one-shot");
    wr(3'h1, 8'h40);
    step(40);
    busyCnt(180);
    check({15'h0, hi >= 56 && hi <= 64}, 16'h0001, "once per second duty");
    // Shutdown keeps the last result; continuous read in and out.
    wr(3'h1, 8'h60);
    tempCode = 16'h1000;
    busyCnt(100);
    check(hi[15:0], 16'h0000, "shutdown busy");
    rdr(8'h50, 16);
    check(rd, COOL, "result in shutdown");
    rdr(8'h54, 0);
    for (int i = 0; i < 2; i++) begin
      spi_u.frame(32'h0, 16, rd);
      check(rd, COOL, "stream burst");
    end
    spi_u.frame(32'hffffffff, 32, rd);
    rdr(8'h48, 8);
    check(rd, 16'h0060, "read after port reset");
    rdr(8'h54, 0);
    spi_u.frame({8'h50, 24'h000000}, 24, rd);
    check(rd, COOL, "exit burst");
    rdr(8'h48, 8);
    check(rd, 16'h0060, "read after exit");
    wr(3'h1, 8'h00);
    check({15'h0, convBusy}, 16'h0000, "wake delay");
    step(8);
    check({15'h0, convBusy}, 16'h0001, "conversion after wake");
    rdr(8'h54, 0);
    spi_u.frame(32'h0, 16, rd);
    check(rd, 16'h0000, "stream during conversion");
    spi_u.frame({8'h50, 24'h000000}, 24, rd);
    results();
  end
endmodule
